// ===== acsf_pkg.sv
// constants and carrier types for the actuator control and status frame block
package acsf_pkg;
	// ***************************************************************
	// frame geometry
	// ***************************************************************
	localparam int          FRAME_BITS    = 16;           // bits per serial frame
	localparam int          DRIVER_COUNT  = 11;           // switched drivers
	localparam int          STAGE_COUNT   = 5;            // stages with a high and a low side
	localparam logic [4:0]  FRAME_COUNT   = 5'h10;        // counter value after a full frame
	// ***************************************************************
	// control word fields
	// ***************************************************************
	localparam int          CTL_SELECT    = 0;            // status word select
	localparam int          CTL_DRV_LO    = 1;            // first driver bit
	localparam int          CTL_DRV_HI    = 11;           // last driver bit
	localparam int          CTL_MON_LO    = 12;           // monitor / standby field low bit
	localparam int          CTL_MON_HI    = 13;           // monitor / standby field high bit
	localparam int          CTL_LOCKOUT   = 14;           // supply lockout mode
	localparam int          CTL_CLEAR     = 15;           // clear all status flags
	localparam logic [15:0] CTL_RESET     = 16'h0000;     // reset value: standby, all off
	// test mode half selects, indices into the driver vector (bit number minus one)
	localparam int          TST_A_LO      = 4;            // control bit 5
	localparam int          TST_A_HI      = 5;            // control bit 6
	localparam int          TST_B_LO      = 6;            // control bit 7
	localparam int          TST_B_HI      = 7;            // control bit 8
	// ***************************************************************
	// status word fields
	// ***************************************************************
	localparam int          STS_NOFAULT   = 0;            // summary, high when fault free
	localparam int          STS_W0_TSD    = 12;           // word 0 thermal shutdown
	localparam int          STS_W0_UV     = 13;           // word 0 supply undervoltage
	localparam int          STS_W0_OV     = 14;           // word 0 supply overvoltage
	localparam int          STS_W1_TWARN  = 12;           // word 1 temperature warning
	localparam int          STS_W1_CPOFF  = 13;           // word 1 charge pump off
	localparam logic        STS_TOP       = 1'b1;         // bit 15 of both words
	localparam logic        STS_UNUSED    = 1'b0;         // word 1 bit 14
	localparam logic [15:0] STS_RESET     = 16'h8001;     // transmit word at reset: fault free
	// ***************************************************************
	// monitor multiplexer codes
	// ***************************************************************
	typedef enum logic [1:0] {
		ACSF_MON_STANDBY = 2'b00,                        // standby, all drivers off
		ACSF_MON_OUT_A   = 2'b01,                        // full bridge output a
		ACSF_MON_OUT_B   = 2'b10,                        // full bridge output b
		ACSF_MON_HEATER  = 2'b11                         // heater high side output
	} acsf_mon_t;
	// ***************************************************************
	// carriers
	// ***************************************************************
	typedef struct packed {
		logic [10:0] overcurrent;                        // per driver overcurrent
		logic [10:0] open_load;                          // per driver open load
		logic        overvoltage;                        // supply over limit
		logic        undervoltage;                       // supply under limit
		logic        thermal_shutdown;                   // junction shutdown
		logic        charge_pump_off;                    // charge pump not running
		logic        temp_warning;                       // junction warning
	} acsf_fault_t;
	typedef struct packed {
		logic [10:0] driver_on;                          // driver enables, bit i = control bit i+1
		logic        half_a_en;                          // split stage half a enable
		logic        half_b_en;                          // split stage half b enable
		logic        standby;                            // device in standby
		acsf_mon_t   monitor;                            // current monitor routing
	} acsf_drive_t;
endpackage

// ===== acsf_ctrl.sv
// control word, status words and serial frame logic of the actuator driver
`timescale 1ns/1ns
`default_nettype none
// Contract
// - control bits 1..11 each switch one driver
// - never both sides of a stage on
// - status 0 bits 1..11 flag overcurrent
// - status 1 bits 1..11 flag open load
// - bit 0 is NOR of bits 1..14 of both words
// - fault bit visible on output at select
// - control bit 0 picks returned status word
// - bit 15 clears flags at frame end
// - lockout holds drivers off until cleared
// - test mode picks split halves by bits 5..8
module acsf_ctrl (
	input  wire logic               clock,            // core clock, 50 MHz
	input  wire logic               rst_n,            // async reset, active low
	input  wire logic               clk_en,           // core clock enable
	input  wire logic               link_clock,       // serial clock from master
	input  wire logic               chip_select_low,  // frame select, active low
	input  wire logic               serial_in,        // serial data from master
	output logic                    serial_out,       // serial data to master
	output logic                    serial_out_oe,    // high while serial_out driven
	input  wire logic               test_mode,        // split stage test mode pin
	input  wire acsf_pkg::acsf_fault_t fault_in,      // raw fault detectors
	output acsf_pkg::acsf_drive_t   drive             // driver enables and monitor
);
	// ***************************************************************
	// functions
	// ***************************************************************
	// drop both sides of any stage whose two sides are requested
	function automatic logic [10:0] interlock(input logic [10:0] req);
		logic [10:0] res;
		res = req;
		for (int s = 0; s < acsf_pkg::STAGE_COUNT; s++)
		begin
			if (req[2*s] && req[2*s+1])
			begin
				res[2*s]   = 1'b0;
				res[2*s+1] = 1'b0;
			end
		end
		return res;
	endfunction
	// two bits of a pair both high
	function automatic logic pair_high(input logic [10:0] v, input int lo, input int hi);
		return v[lo] & v[hi];
	endfunction

	// ***************************************************************
	// link domain: frame counter and input shifter
	// ***************************************************************
	logic        frame_rst_n;                         // held in reset outside frames
	logic [4:0]  bit_count;                           // rising edges seen this frame
	logic [15:0] in_shift;                            // received bits, lsb first
	logic        out_valid;                           // a falling edge has shifted
	logic        out_bit;                             // shifted output bit
	logic [15:0] tx_word;                             // status word, quasi static

	// the frame ends with chip select, so the counter needs no link edge to stop
	assign frame_rst_n = rst_n & ~chip_select_low;

	// count rising edges, shift in only the first sixteen bits
	always_ff @(posedge link_clock or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			bit_count <= 5'h00;
		else if (bit_count != acsf_pkg::FRAME_COUNT)
			bit_count <= bit_count + 5'h01;
	end

	// shift register keeps its word after the frame for the core to take
	always_ff @(posedge link_clock or negedge rst_n)
	begin
		if (!rst_n)
			in_shift <= 16'h0000;
		else if (bit_count != acsf_pkg::FRAME_COUNT)
			in_shift <= {serial_in, in_shift[15:1]};
	end

	// falling edge presents the next status bit, trailing bits read low
	always_ff @(negedge link_clock or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			out_valid <= 1'b0;
			out_bit   <= 1'b0;
		end
		else
		begin
			out_valid <= 1'b1;
			out_bit   <= (bit_count == acsf_pkg::FRAME_COUNT) ? 1'b0 : tx_word[bit_count[3:0]];
		end
	end

	// before the first falling edge the summary bit is shown, so polling works
	assign serial_out    = out_valid ? out_bit : tx_word[acsf_pkg::STS_NOFAULT];
	assign serial_out_oe = ~chip_select_low;

	// ***************************************************************
	// core domain: synchronisers
	// ***************************************************************
	localparam int SYNC_W = $bits(acsf_pkg::acsf_fault_t) + 2;
	// select bit resets to its idle high level, so no false frame end follows reset
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {{(SYNC_W-2){1'b0}}, 2'b10};
	logic [SYNC_W-1:0] sync_1;                        // first stage, read only by sync_2
	logic [SYNC_W-1:0] sync_2;                        // second stage
	logic              cs_low_prev;                   // previous synced select
	acsf_pkg::acsf_fault_t flt;                       // synced faults
	logic              cs_low_s;                      // synced select
	logic              test_s;                        // synced test mode

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_1      <= SYNC_IDLE;
			sync_2      <= SYNC_IDLE;
			cs_low_prev <= 1'b1;
		end
		else if (clk_en)
		begin
			sync_1      <= {fault_in, chip_select_low, test_mode};
			sync_2      <= sync_1;
			cs_low_prev <= cs_low_s;
		end
	end
	assign flt      = sync_2[SYNC_W-1:2];
	assign cs_low_s = sync_2[1];
	assign test_s   = sync_2[0];

	// ***************************************************************
	// core domain: control word
	// ***************************************************************
	logic [15:0] control_word;                        // last accepted control word
	logic        frame_end;                           // synced chip select rising
	assign frame_end = ~cs_low_prev & cs_low_s;

	// the link shifter is static once select is high, so taking it then is safe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			control_word <= acsf_pkg::CTL_RESET;
		else if (clk_en && frame_end)
			control_word <= in_shift;
	end

	// ***************************************************************
	// core domain: sticky status flags
	// ***************************************************************
	logic [10:0] oc_flag;                             // overcurrent flags
	logic [10:0] ol_flag;                             // open load flags
	logic [4:0]  sys_flag;                            // ov, uv, tsd, pump, warning
	logic [4:0]  sys_raw;                             // live system faults
	logic        clear_now;                           // clear request at frame end
	assign sys_raw   = {flt.overvoltage, flt.undervoltage, flt.thermal_shutdown,
		flt.charge_pump_off, flt.temp_warning};
	assign clear_now = frame_end & in_shift[acsf_pkg::CTL_CLEAR];

	// set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oc_flag  <= 11'h000;
			ol_flag  <= 11'h000;
			sys_flag <= 5'h00;
		end
		else if (clk_en)
		begin
			oc_flag  <= (clear_now ? 11'h000 : oc_flag) | flt.overcurrent;
			ol_flag  <= (clear_now ? 11'h000 : ol_flag) | flt.open_load;
			sys_flag <= (clear_now ? 5'h00 : sys_flag) | sys_raw;
		end
	end

	// ***************************************************************
	// status words and transmit snapshot
	// ***************************************************************
	logic        no_fault;                            // summary bit
	logic [15:0] status_word_0;                       // overcurrent and supply word
	logic [15:0] status_word_1;                       // open load and thermal word
	assign no_fault = ~(|oc_flag | |ol_flag | |sys_flag);
	assign status_word_0 = {acsf_pkg::STS_TOP, sys_flag[4], sys_flag[3], sys_flag[2],
		oc_flag, no_fault};
	assign status_word_1 = {acsf_pkg::STS_TOP, acsf_pkg::STS_UNUSED, sys_flag[1],
		sys_flag[0], ol_flag, no_fault};

	// frozen while select is low, so the link reads a stable word
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			tx_word <= acsf_pkg::STS_RESET;
		else if (clk_en && cs_low_s)
			tx_word <= control_word[acsf_pkg::CTL_SELECT] ? status_word_1 : status_word_0;
	end

	// ***************************************************************
	// driver enables
	// ***************************************************************
	logic [10:0] drv_req;                             // requested drivers
	logic        standby_sel;                         // bits 13:12 both low
	logic        supply_block;                        // supply fault holds drivers off
	logic        all_block;                           // every driver held off
	logic        a_sel;                               // test half a pattern
	logic        b_sel;                               // test half b pattern
	logic [10:0] next_drv;                            // driver enables after gating
	assign drv_req      = control_word[acsf_pkg::CTL_DRV_HI:acsf_pkg::CTL_DRV_LO];
	assign standby_sel  = control_word[acsf_pkg::CTL_MON_HI:acsf_pkg::CTL_MON_LO] == 2'b00;
	// lockout mode waits for the flag to be cleared, else follows the live level
	assign supply_block = control_word[acsf_pkg::CTL_LOCKOUT] ? (sys_flag[4] | sys_flag[3])
		: (flt.overvoltage | flt.undervoltage);
	assign all_block    = standby_sel | supply_block | sys_flag[2];
	assign next_drv     = all_block ? 11'h000 : (interlock(drv_req) & ~oc_flag);
	assign a_sel        = pair_high(drv_req, acsf_pkg::TST_A_LO, acsf_pkg::TST_A_HI);
	assign b_sel        = pair_high(drv_req, acsf_pkg::TST_B_LO, acsf_pkg::TST_B_HI);

	// registered outputs, reset to everything off
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drive.driver_on <= 11'h000;
			drive.half_a_en <= 1'b0;
			drive.half_b_en <= 1'b0;
			drive.standby   <= 1'b1;
			drive.monitor   <= acsf_pkg::ACSF_MON_STANDBY;
		end
		else if (clk_en)
		begin
			drive.driver_on <= next_drv;
			// in test mode one half at a time; both patterns set picks neither
			drive.half_a_en <= test_s ? (a_sel & ~b_sel) : 1'b1;
			drive.half_b_en <= test_s ? (b_sel & ~a_sel) : 1'b1;
			drive.standby   <= standby_sel;
			drive.monitor   <= acsf_pkg::acsf_mon_t'(control_word[13:12]);
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	stage_no_shoot_a: assert property (
		!(|(drive.driver_on[9:0] & {drive.driver_on[8:0], 1'b0} & 10'h2AA)))
		else $error("both sides of a stage on");
	driver_follow_a: assert property (
		clk_en && !all_block && oc_flag == 11'h000 && !drv_req[10]
		|=> !drive.driver_on[10])
		else $error("heater driver on without request");
	summary_nor_a: assert property (
		status_word_0[0] == ~(|status_word_0[14:1] | |status_word_1[14:1]))
		else $error("summary bit wrong");
	top_bit_a: assert property (
		status_word_0[15] && status_word_1[15] && !status_word_1[14])
		else $error("fixed status bits wrong");
	oc_sticky_a: assert property (
		clk_en && flt.overcurrent[2] |=> oc_flag[2] && status_word_0[3])
		else $error("overcurrent not flagged");
	ol_sticky_a: assert property (
		clk_en && flt.open_load[7] |=> ol_flag[7] && status_word_1[8])
		else $error("open load not flagged");
	clear_frame_a: assert property (
		clk_en && clear_now && flt == '0 |=> no_fault)
		else $error("clear did not empty flags");
	oc_disable_a: assert property (
		clk_en && oc_flag[2] |=> !drive.driver_on[2])
		else $error("driver on with overcurrent flag");
	lockout_hold_a: assert property (
		clk_en && control_word[14] && sys_flag[4] |=> drive.driver_on == 11'h000)
		else $error("lockout let drivers on");
	standby_off_a: assert property (
		clk_en && standby_sel |=> drive.standby && drive.driver_on == 11'h000)
		else $error("standby left drivers on");
	select_word_a: assert property (
		clk_en && cs_low_s && control_word[0] |=> tx_word == $past(status_word_1))
		else $error("wrong status word chosen");
	test_none_a: assert property (
		clk_en && test_s && a_sel && b_sel |=> !drive.half_a_en && !drive.half_b_en)
		else $error("test mode half active");
	poll_fault_a: assert property (
		!cs_low_s && !out_valid |-> serial_out == tx_word[0])
		else $error("poll output not summary");
	output_enable_a: assert property (
		serial_out_oe == !chip_select_low)
		else $error("output enable not following select");
	capture_word_a: assert property (
		clk_en && frame_end |=> control_word == $past(in_shift))
		else $error("frame word not taken at frame end");

	// cover the main scenarios
	frame_cv:   cover property (frame_end ##1 control_word != 16'h0000);
	poll_cv:    cover property (!cs_low_s && !out_valid && !no_fault);
	clear_cv:   cover property (clear_now && !no_fault);
	lockout_cv: cover property (control_word[14] && sys_flag[4] && !flt.overvoltage);
	test_cv:    cover property (test_s && a_sel && !b_sel);
endmodule
`default_nettype wire

// ===== acsf_link_master.sv
// behavioural serial master that trades frames with the actuator block
`timescale 1ns/1ns
`default_nettype none
module acsf_link_master (
	output logic      chip_select_low, // frame select, active low
	output logic      link_clock,      // serial clock, idle low
	output logic      serial_in,       // data to the block
	input  wire logic serial_out,      // data from the block
	input  wire logic serial_out_oe    // high while block drives serial_out
);
	// ***************************************************************
	// idle levels
	// ***************************************************************
	// clock stands still between frames, as a real master leaves it
	initial
	begin
		chip_select_low = 1'b1;
		link_clock      = 1'b0;
		serial_in       = 1'b0;
	end
	// one whole frame, lsb first both ways, 125 ns clock
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic ok);
		chip_select_low = 1'b0;
		#400;
		for (int i = 0; i < 16; i++)
		begin
			serial_in  = tx[i];
			#63;
			rx[i]      = serial_out;   // taken at our rising edge
			link_clock = 1'b1;
			#62;
			link_clock = 1'b0;
		end
		#100;
		chip_select_low = 1'b1;
		// released data line falls to its pull-down level
		serial_in = 1'b0;
		// frames of all-low or all-high upper bits mean a lost logic supply
		ok = (|rx[15:1]) && !(&rx[15:1]);
	endtask
	// fault poll: select only, no clock edges
	task automatic poll(output logic lvl, output logic en);
		chip_select_low = 1'b0;
		#200;
		lvl             = serial_out;
		en              = serial_out_oe;
		chip_select_low = 1'b1;
		#200;
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the actuator control and status frame block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// ***************************************************************
	// signals
	// ***************************************************************
	logic                  clock;      // core clock, 50 MHz
	logic                  rst_n;      // reset, active low
	logic                  clk_en;     // core clock enable
	logic                  test_mode;  // split stage test pin
	acsf_pkg::acsf_fault_t flt;        // fault detector levels
	acsf_pkg::acsf_drive_t drv;        // driver enables seen
	wire                   csl;        // chip select low
	wire                   lclk;       // link clock
	wire                   sin;        // serial in
	wire                   sout;       // serial out
	wire                   soe;        // serial out enable
	int                    err_total;  // mismatches
	int                    cmp_count;  // comparisons
	logic [15:0]           rx;         // last status frame
	logic                  ok;         // last frame looked valid
	logic                  lvl;        // polled summary level
	logic                  en;         // polled output enable
	// ***************************************************************
	// instances
	// ***************************************************************
	// clk_en stays high except in the freeze scenario
	acsf_ctrl DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .link_clock(lclk),
		.chip_select_low(csl), .serial_in(sin), .serial_out(sout), .serial_out_oe(soe),
		.test_mode(test_mode), .fault_in(flt), .drive(drv));
	acsf_link_master master (.chip_select_low(csl), .link_clock(lclk), .serial_in(sin),
		.serial_out(sout), .serial_out_oe(soe));
	// core clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// inputs move 2 ns after the edge, always
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	// capture takes 3 edges after select rises, drive one more
	task automatic send(input logic [15:0] tx);
		master.frame(tx, rx, ok);
		cyc(6);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_reset;
		chk("drivers", 16'h0000, {5'h00, drv.driver_on});
		chk("standby halves", 16'h0007, {13'h0, drv.standby, drv.half_a_en, drv.half_b_en});
		chk("oe idle", 16'h0000, {15'h0, soe});
		master.poll(lvl, en);
		chk("summary", 16'h0003, {14'h0, en, lvl});
		$display("test reset done");
	endtask
	// walking one over all drivers, cycling the monitor codes
	task automatic t_drivers;
		logic [1:0] m;
		for (int i = 0; i < acsf_pkg::DRIVER_COUNT; i++)
		begin
			m = 2'((i % 3) + 1);
			send({2'b00, m, 11'(1 << i), 1'b0});
			chk("drivers", 16'(1 << i), {5'h00, drv.driver_on});
			chk("monitor", {14'h0, m}, {14'h0, drv.monitor});
		end
		send(16'h100E);
		chk("interlock", 16'h0004, {5'h00, drv.driver_on});
		send(16'h000E);
		chk("standby", 16'h0001, {15'h0, drv.standby});
		chk("drivers", 16'h0000, {5'h00, drv.driver_on});
		$display("test drivers done");
	endtask
	// sticky flags, word select by previous frame, clear at frame end
	task automatic t_faults;
		send(16'h100A);
		flt = {11'h004, 11'h081, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		cyc(5);
		flt = '0;
		cyc(5);
		chk("drivers", 16'h0001, {5'h00, drv.driver_on});
		master.poll(lvl, en);
		chk("summary", 16'h0002, {14'h0, en, lvl});
		send(16'h100B);
		chk("status 0", {acsf_pkg::STS_TOP, 3'b100, 11'h004, 1'b0}, rx);
		chk("valid", 16'h0001, {15'h0, ok});
		send(16'h900B);
		chk("status 1", {acsf_pkg::STS_TOP, acsf_pkg::STS_UNUSED, 2'b11, 11'h081, 1'b0}, rx);
		send(16'h100A);
		chk("cleared", {acsf_pkg::STS_TOP, 14'h0, 1'b1}, rx);
		chk("drivers", 16'h0005, {5'h00, drv.driver_on});
		$display("test faults done");
	endtask
	// supply lockout latched versus automatic recovery
	task automatic t_lockout;
		send(16'h7800);
		flt.overvoltage = 1'b1;
		cyc(5);
		flt = '0;
		cyc(5);
		chk("locked", 16'h0000, {5'h00, drv.driver_on});
		send(16'hF800);
		chk("unlocked", 16'h0400, {5'h00, drv.driver_on});
		send(16'h3800);
		flt.undervoltage = 1'b1;
		cyc(6);
		chk("supply low", 16'h0000, {5'h00, drv.driver_on});
		flt = '0;
		cyc(6);
		chk("recovered", 16'h0400, {5'h00, drv.driver_on});
		send(16'hB800);
		$display("test lockout done");
	endtask
	// all sixteen settings of bits 5..8 in test mode
	task automatic t_test;
		logic [3:0] v;
		logic       a;
		logic       b;
		test_mode = 1'b1;
		cyc(4);
		for (int n = 0; n < 16; n++)
		begin
			v = 4'(n);
			send({7'h08, v, 5'h00});
			a = v[0] & v[1] & ~(v[2] & v[3]);
			b = v[2] & v[3] & ~(v[0] & v[1]);
			chk("halves", {14'h0, a, b}, {14'h0, drv.half_a_en, drv.half_b_en});
		end
		test_mode = 1'b0;
		$display("test split halves done");
	endtask
	// core frozen across a frame end: the word is taken only once enabled again
	task automatic t_freeze;
		master.frame(16'h1002, rx, ok);
		clk_en = 1'b0;
		cyc(6);
		chk("frozen", 16'h0000, {5'h00, drv.driver_on});
		clk_en = 1'b1;
		cyc(6);
		chk("released", 16'h0001, {5'h00, drv.driver_on});
		$display("test freeze done");
	endtask
	// ***************************************************************
	// main sequence and watchdog
	// ***************************************************************
	initial
	begin
		rst_n     = 1'b0;
		clk_en    = 1'b1;
		test_mode = 1'b0;
		flt       = '0;
		err_total = 0;
		cmp_count = 0;
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
		t_reset;
		t_drivers;
		t_faults;
		t_lockout;
		t_test;
		t_freeze;
		print_verdict;
	end
	// a hang counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge clock);
		err_total++;
		print_verdict;
	end
endmodule
`default_nettype wire
